// *** src/rfps_dev.sv ***
// Purpose: Audio processor end: reset, init, fast-load and low-power sequencing
// Assumes: Pins arrive unsynchronised; one master clock
// Notes: Control requests to this device's address get one ack or nak pulse, none before init ends
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`include "rfps_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rfps_dev #(
  parameter int INIT_CYCLES = `RFPS_INIT_CYC,
  parameter int EQ_WORDS = `RFPS_EQ_WORDS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  rfps_link_if.dev lnk,
  output logic o_ready,
  output logic o_fast_load,
  output logic o_low_power,
  output logic o_audio_accept,
  output logic o_audio_run,
  output logic [23:0] o_volume,
  output logic [23:0] o_gain_a,
  output logic [23:0] o_gain_b,
  output logic [7:0] o_bass,
  output logic [7:0] o_treble
);
  localparam int CMAX = (INIT_CYCLES > 16) ? INIT_CYCLES : 16;
  localparam int CW = $clog2(CMAX + 1);
  localparam int AW = $clog2(EQ_WORDS);

  logic rst_m_q;
  logic rst_s_q;
  logic pd_m_q;
  logic pd_s_q;
  rfps_pkg::rfps_dev_st_t st_q;
  rfps_pkg::rfps_dev_st_t st_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [AW-1:0] ptr_q;
  logic [7:0] main_q;
  logic [23:0] vol_q;
  logic [23:0] gain_a_q;
  logic [23:0] gain_b_q;
  logic [7:0] bass_q;
  logic [7:0] treb_q;
  logic [1:0] addr_q;
  logic ack_q;
  logic nak_q;
  logic [23:0] rdata_q;
  logic ready_q;
  logic lowpwr_q;
  logic accept_q;
  logic run_q;
  logic [23:0] eq_ram [EQ_WORDS];

  function automatic logic is_eq(input logic [7:0] a);
    is_eq = (9'(a) >= 9'(`RFPS_REG_EQ_BASE)) &&
            (9'(a) < 9'(`RFPS_REG_EQ_BASE) + 9'(EQ_WORDS));
  endfunction

  function automatic logic is_known(input logic [7:0] a);
    is_known = (a == `RFPS_REG_MAIN) || (a == `RFPS_REG_VOL) ||
               (a == `RFPS_REG_TREB) || (a == `RFPS_REG_BASS) ||
               (a == `RFPS_REG_GAIN_A) || (a == `RFPS_REG_GAIN_B) || is_eq(a);
  endfunction

  function automatic logic [23:0] eq_init(input logic [AW-1:0] idx);
    // b0 of each biquad at unity, the rest zero: an all-pass section
    eq_init = ((int'(idx) % `RFPS_COEF_PER_BQ) == 0) ? `RFPS_UNITY : `RFPS_MUTE;
  endfunction

  // Pin decode
  wire pin_rst = !rst_s_q;
  wire rst_ok = cnt_q >= CW'(`RFPS_RST_MIN_CYC - 1);
  wire init_done = cnt_q == CW'(INIT_CYCLES - 1);
  wire init_go = (st_d == rfps_pkg::RFPS_D_INIT) && (st_q != rfps_pkg::RFPS_D_INIT);
  wire init_end = (st_q == rfps_pkg::RFPS_D_INIT) && (st_d == rfps_pkg::RFPS_D_RUN);
  wire fl = main_q[`RFPS_FL_BIT];
  wire in_run = st_q == rfps_pkg::RFPS_D_RUN;
  wire in_init = st_q == rfps_pkg::RFPS_D_INIT;

  // Control request decode
  wire [7:0] rg = lnk.ctl_reg;
  wire req_hit = in_run && lnk.ctl_req && (lnk.ctl_dev == addr_q) && !ack_q && !nak_q;
  wire tone = (rg == `RFPS_REG_TREB) || (rg == `RFPS_REG_BASS);
  wire refuse = !is_known(rg) || (lnk.ctl_we && fl && tone);
  wire wr_ok = req_hit && lnk.ctl_we && !refuse;
  wire [7:0] eq_off = rg - `RFPS_REG_EQ_BASE;
  wire [AW-1:0] eq_idx = eq_off[AW-1:0];
  wire bus_eq_we = wr_ok && is_eq(rg);
  wire ram_we = in_init || bus_eq_we;
  wire [AW-1:0] ram_wa = in_init ? ptr_q : eq_idx;
  wire [23:0] ram_wd = in_init ? eq_init(ptr_q) : lnk.ctl_wdata;
  wire [23:0] eq_rd = eq_ram[eq_idx];
  wire [23:0] rd_val = (rg == `RFPS_REG_MAIN) ? {16'h0000, main_q} :
                       (rg == `RFPS_REG_VOL) ? vol_q :
                       (rg == `RFPS_REG_TREB) ? {16'h0000, treb_q} :
                       (rg == `RFPS_REG_BASS) ? {16'h0000, bass_q} :
                       (rg == `RFPS_REG_GAIN_A) ? gain_a_q :
                       (rg == `RFPS_REG_GAIN_B) ? gain_b_q :
                       is_eq(rg) ? eq_rd : 24'h000000;

  // Two-flop synchronisers for the asynchronous pins
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
      pd_m_q <= 1'b0;
      pd_s_q <= 1'b0;
    end else begin
      rst_m_q <= lnk.rst_b;
      rst_s_q <= rst_m_q;
      pd_m_q <= lnk.low_power_request_pin;
      pd_s_q <= pd_m_q;
    end
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      rfps_pkg::RFPS_D_UNDEF: begin
        if (pin_rst) begin
          st_d = rfps_pkg::RFPS_D_RESET;
          cnt_d = '0;
        end
      end
      rfps_pkg::RFPS_D_RESET: begin
        if (pd_s_q) begin
          st_d = rfps_pkg::RFPS_D_LOWPWR;
        end else if (!pin_rst) begin
          st_d = rst_ok ? rfps_pkg::RFPS_D_INIT : rfps_pkg::RFPS_D_UNDEF;
          cnt_d = '0;
        end else if (!rst_ok) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      rfps_pkg::RFPS_D_INIT: begin
        if (pin_rst) begin
          st_d = pd_s_q ? rfps_pkg::RFPS_D_LOWPWR : rfps_pkg::RFPS_D_RESET;
          cnt_d = '0;
        end else if (init_done) begin
          st_d = rfps_pkg::RFPS_D_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      rfps_pkg::RFPS_D_RUN: begin
        if (pin_rst) begin
          st_d = pd_s_q ? rfps_pkg::RFPS_D_LOWPWR : rfps_pkg::RFPS_D_RESET;
          cnt_d = '0;
        end
      end
      rfps_pkg::RFPS_D_LOWPWR: begin
        if (!pd_s_q && !pin_rst) begin
          st_d = rfps_pkg::RFPS_D_INIT;
          cnt_d = '0;
        end
      end
      default: begin
        st_d = rfps_pkg::RFPS_D_UNDEF;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= rfps_pkg::RFPS_D_UNDEF;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Coefficient RAM: init sweep has priority, bus writes only in run
  always_ff @(posedge i_clk) begin
    if (ram_we) begin
      eq_ram[ram_wa] <= ram_wd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || init_go) begin
      ptr_q <= '0;
    end else if (in_init && (ptr_q != AW'(EQ_WORDS - 1))) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      main_q <= `RFPS_MAIN_RST;
      vol_q <= `RFPS_MUTE;
      gain_a_q <= `RFPS_MUTE;
      gain_b_q <= `RFPS_MUTE;
      bass_q <= `RFPS_TONE_FLAT;
      treb_q <= `RFPS_TONE_FLAT;
    end else if (init_go) begin
      main_q[`RFPS_FL_BIT] <= 1'b1;
      vol_q <= `RFPS_MUTE;
      gain_a_q <= `RFPS_UNITY;
      gain_b_q <= `RFPS_MUTE;
      bass_q <= `RFPS_TONE_FLAT;
      treb_q <= `RFPS_TONE_FLAT;
    end else if (wr_ok) begin
      case (rg)
        `RFPS_REG_MAIN: main_q <= lnk.ctl_wdata[7:0];
        `RFPS_REG_VOL: vol_q <= lnk.ctl_wdata;
        `RFPS_REG_TREB: treb_q <= lnk.ctl_wdata[7:0];
        `RFPS_REG_BASS: bass_q <= lnk.ctl_wdata[7:0];
        `RFPS_REG_GAIN_A: gain_a_q <= lnk.ctl_wdata;
        `RFPS_REG_GAIN_B: gain_b_q <= lnk.ctl_wdata;
        default: main_q <= main_q;
      endcase
    end
  end

  // Address pins are taken as init ends so the port is live at once
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr_q <= 2'h0;
    end else if (init_end) begin
      addr_q <= {lnk.bus_addr_select_b, lnk.bus_addr_select_a};
    end
  end

  // Answer pulses and status flags
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
      nak_q <= 1'b0;
      rdata_q <= 24'h000000;
      ready_q <= 1'b0;
      lowpwr_q <= 1'b0;
      accept_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      ack_q <= req_hit && !refuse;
      nak_q <= req_hit && refuse;
      if (req_hit) begin
        rdata_q <= rd_val;
      end
      ready_q <= in_run;
      lowpwr_q <= st_q == rfps_pkg::RFPS_D_LOWPWR;
      accept_q <= in_run && !fl;
      run_q <= in_run && !fl && !ram_we;
    end
  end

  assign lnk.ctl_ack = ack_q;
  assign lnk.ctl_nak = nak_q;
  assign lnk.ctl_rdata = rdata_q;
  assign o_ready = ready_q;
  assign o_fast_load = main_q[`RFPS_FL_BIT];
  assign o_low_power = lowpwr_q;
  assign o_audio_accept = accept_q;
  assign o_audio_run = run_q;
  assign o_volume = vol_q;
  assign o_gain_a = gain_a_q;
  assign o_gain_b = gain_b_q;
  assign o_bass = bass_q;
  assign o_treble = treb_q;
endmodule // rfps_dev
`default_nettype wire

// *** src/rfps_defines.svh ***
// Purpose: Shared constants of the reset, fast-load and power-down sequencer
// Assumes: 40 MHz master clock on both ends
// Notes: Times stay in their own unit; cycle counts derive from them
`ifndef RFPS_DEFINES_SVH
`define RFPS_DEFINES_SVH

`define RFPS_CLK_HZ 40000000
`define RFPS_CLK_NS 25
`define RFPS_INIT_MS 5
`define RFPS_INIT_CYC (`RFPS_CLK_HZ / 1000 * `RFPS_INIT_MS)
`define RFPS_GAP_NS 1000
`define RFPS_GAP_CYC ((`RFPS_GAP_NS + `RFPS_CLK_NS - 1) / `RFPS_CLK_NS)
`define RFPS_RST_MIN_CYC 10
`define RFPS_XFER_TMO 250000

`define RFPS_EQ_WORDS 60
`define RFPS_COEF_PER_BQ 5

`define RFPS_REG_MAIN 8'h01
`define RFPS_REG_VOL 8'h04
`define RFPS_REG_TREB 8'h05
`define RFPS_REG_BASS 8'h06
`define RFPS_REG_GAIN_A 8'h07
`define RFPS_REG_GAIN_B 8'h08
`define RFPS_REG_EQ_BASE 8'h40

`define RFPS_FL_BIT 7
`define RFPS_MAIN_RST 8'h00
`define RFPS_UNITY 24'h100000
`define RFPS_MUTE 24'h000000
`define RFPS_TONE_FLAT 8'h00

`define RFPS_AV_CTRL 2'h0
`define RFPS_AV_WCMD 2'h1
`define RFPS_AV_STAT 2'h2
`define RFPS_AV_RCMD 2'h3
`define RFPS_CTRL_SEL 1:0
`define RFPS_CTRL_TGT 3:2
`define RFPS_OP_RST 4
`define RFPS_OP_PD_IN 5
`define RFPS_OP_PD_OUT 6
`define RFPS_CMD_REG 31:24
`define RFPS_CMD_DATA 23:0

`endif

// *** src/rfps_pkg.sv ***
// Purpose: Types shared by both ends of the sequencer link
// Assumes: Nothing beyond the defines header
// Notes: States only; numbers live in the defines header
package rfps_pkg;
  typedef enum logic [2:0] {
    RFPS_D_UNDEF,
    RFPS_D_RESET,
    RFPS_D_INIT,
    RFPS_D_RUN,
    RFPS_D_LOWPWR
  } rfps_dev_st_t;

  typedef enum logic [2:0] {
    RFPS_H_RST,
    RFPS_H_IDLE,
    RFPS_H_PDGAP,
    RFPS_H_PD,
    RFPS_H_UPGAP,
    RFPS_H_XFER
  } rfps_host_st_t;
endpackage

// *** src/rfps_link_if.sv ***
// Purpose: Pins and control channel between host and audio processor
// Assumes: Single clock shared by both ends
// Notes: Reset and power-down pins may still change at any time
`timescale 1ns/1ps
`default_nettype none
interface rfps_link_if;
  logic rst_b;
  logic low_power_request_pin;
  logic bus_addr_select_a;
  logic bus_addr_select_b;
  logic ctl_req;
  logic ctl_we;
  logic [1:0] ctl_dev;
  logic [7:0] ctl_reg;
  logic [23:0] ctl_wdata;
  logic ctl_ack;
  logic ctl_nak;
  logic [23:0] ctl_rdata;

  modport dev (
    input rst_b, low_power_request_pin, bus_addr_select_a, bus_addr_select_b,
    input ctl_req, ctl_we, ctl_dev, ctl_reg, ctl_wdata,
    output ctl_ack, ctl_nak, ctl_rdata
  );

  modport host (
    output rst_b, low_power_request_pin, bus_addr_select_a, bus_addr_select_b,
    output ctl_req, ctl_we, ctl_dev, ctl_reg, ctl_wdata,
    input ctl_ack, ctl_nak, ctl_rdata
  );
endinterface
`default_nettype wire

// *** src/rfps_host.sv ***
// Purpose: Host end: drives reset, power-down and address pins, issues requests
// Assumes: Avalon-MM slave with waitrequest, word addresses
// Notes: One operation at a time; busy status shows when a new one may start
`include "rfps_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rfps_host #(
  parameter int XFER_TMO = `RFPS_XFER_TMO,
  parameter int RST_HOLD = `RFPS_RST_MIN_CYC,
  parameter int GAP_CYC = `RFPS_GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  rfps_link_if.host lnk
);
  localparam int TW = $clog2(XFER_TMO + 1);

  rfps_pkg::rfps_host_st_t st_q;
  logic [TW-1:0] cnt_q;
  logic rst_b_q;
  logic pd_q;
  logic req_q;
  logic we_q;
  logic [1:0] sel_q;
  logic [1:0] tgt_q;
  logic [7:0] reg_q;
  logic [23:0] wdata_q;
  logic [23:0] rdata_q;
  logic ack_f_q;
  logic nak_f_q;
  logic tmo_f_q;
  logic wait_q;
  logic [31:0] rd_q;

  wire av_req = i_avs_read || i_avs_write;
  wire av_done = av_req && !wait_q;
  wire av_wr = av_done && i_avs_write;
  wire ctrl_wr = av_wr && (i_avs_address == `RFPS_AV_CTRL);
  wire wcmd_wr = av_wr && (i_avs_address == `RFPS_AV_WCMD);
  wire rcmd_wr = av_wr && (i_avs_address == `RFPS_AV_RCMD);
  wire idle = st_q == rfps_pkg::RFPS_H_IDLE;
  wire go_rst = ctrl_wr && idle && i_avs_writedata[`RFPS_OP_RST];
  wire go_pdin = ctrl_wr && idle && i_avs_writedata[`RFPS_OP_PD_IN];
  wire go_pdout = ctrl_wr && (st_q == rfps_pkg::RFPS_H_PD) && i_avs_writedata[`RFPS_OP_PD_OUT];
  wire go_xfer = (wcmd_wr || rcmd_wr) && idle;
  wire rst_hit = cnt_q == TW'(RST_HOLD - 1);
  wire gap_hit = cnt_q == TW'(GAP_CYC - 1);
  wire tmo_hit = cnt_q == TW'(XFER_TMO - 1);
  wire [31:0] stat_val = {26'h0000000, !rst_b_q, pd_q, tmo_f_q, nak_f_q, ack_f_q, !idle};
  wire [31:0] rd_val = (i_avs_address == `RFPS_AV_CTRL) ? {28'h0000000, tgt_q, sel_q} :
                       (i_avs_address == `RFPS_AV_STAT) ? stat_val :
                       (i_avs_address == `RFPS_AV_RCMD) ? {8'h00, rdata_q} : 32'h00000000;

  // Avalon slave: one wait cycle, then data stands at the completing edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wait_q <= 1'b1;
      rd_q <= 32'h00000000;
    end else begin
      wait_q <= !(av_req && wait_q);
      if (av_req && wait_q) begin
        rd_q <= rd_val;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sel_q <= 2'h0;
      tgt_q <= 2'h0;
    end else if (ctrl_wr) begin
      sel_q <= i_avs_writedata[`RFPS_CTRL_SEL];
      tgt_q <= i_avs_writedata[`RFPS_CTRL_TGT];
    end
  end

  // Pin and request sequencer; power-up starts with a reset pulse
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= rfps_pkg::RFPS_H_RST;
      cnt_q <= '0;
      rst_b_q <= 1'b0;
      pd_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      reg_q <= 8'h00;
      wdata_q <= 24'h000000;
      rdata_q <= 24'h000000;
      ack_f_q <= 1'b0;
      nak_f_q <= 1'b0;
      tmo_f_q <= 1'b0;
    end else begin
      case (st_q)
        rfps_pkg::RFPS_H_RST: begin
          if (rst_hit) begin
            rst_b_q <= 1'b1;
            st_q <= rfps_pkg::RFPS_H_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        rfps_pkg::RFPS_H_IDLE: begin
          cnt_q <= '0;
          if (go_rst) begin
            rst_b_q <= 1'b0;
            st_q <= rfps_pkg::RFPS_H_RST;
          end else if (go_pdin) begin
            pd_q <= 1'b1;
            st_q <= rfps_pkg::RFPS_H_PDGAP;
          end else if (go_xfer) begin
            req_q <= 1'b1;
            we_q <= wcmd_wr;
            reg_q <= i_avs_writedata[`RFPS_CMD_REG];
            wdata_q <= i_avs_writedata[`RFPS_CMD_DATA];
            ack_f_q <= 1'b0;
            nak_f_q <= 1'b0;
            tmo_f_q <= 1'b0;
            st_q <= rfps_pkg::RFPS_H_XFER;
          end
        end
        rfps_pkg::RFPS_H_PDGAP: begin
          if (gap_hit) begin
            rst_b_q <= 1'b0;
            st_q <= rfps_pkg::RFPS_H_PD;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        rfps_pkg::RFPS_H_PD: begin
          cnt_q <= '0;
          if (go_pdout) begin
            pd_q <= 1'b0;
            st_q <= rfps_pkg::RFPS_H_UPGAP;
          end
        end
        rfps_pkg::RFPS_H_UPGAP: begin
          if (gap_hit) begin
            rst_b_q <= 1'b1;
            st_q <= rfps_pkg::RFPS_H_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        rfps_pkg::RFPS_H_XFER: begin
          if (lnk.ctl_ack || lnk.ctl_nak) begin
            req_q <= 1'b0;
            ack_f_q <= lnk.ctl_ack;
            nak_f_q <= lnk.ctl_nak;
            if (lnk.ctl_ack) begin
              rdata_q <= lnk.ctl_rdata;
            end
            st_q <= rfps_pkg::RFPS_H_IDLE;
          end else if (tmo_hit) begin
            req_q <= 1'b0;
            tmo_f_q <= 1'b1;
            st_q <= rfps_pkg::RFPS_H_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: st_q <= rfps_pkg::RFPS_H_IDLE;
      endcase
    end
  end

  assign o_avs_readdata = rd_q;
  assign o_avs_waitrequest = wait_q;
  assign lnk.rst_b = rst_b_q;
  assign lnk.low_power_request_pin = pd_q;
  assign lnk.bus_addr_select_a = sel_q[0];
  assign lnk.bus_addr_select_b = sel_q[1];
  assign lnk.ctl_req = req_q;
  assign lnk.ctl_we = we_q;
  assign lnk.ctl_dev = tgt_q;
  assign lnk.ctl_reg = reg_q;
  assign lnk.ctl_wdata = wdata_q;
endmodule // rfps_host
`default_nettype wire

// *** verification/rfps_link_assertions.sv ***
// Purpose: Checker of the link pins and control channel between both ends
// Assumes: Instantiated beside the link interface, one clock domain
// Notes: Pin counters start at system reset release
`timescale 1ns/1ps
`default_nettype none
module rfps_link_assertions #(
  parameter int INIT_CYCLES = 100,
  parameter int GAP_CYC = 40,
  parameter int RST_HOLD = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic rst_b,
  input wire logic low_power_request_pin,
  input wire logic ctl_req,
  input wire logic ctl_we,
  input wire logic [7:0] ctl_reg,
  input wire logic [23:0] ctl_wdata,
  input wire logic ctl_ack,
  input wire logic ctl_nak
);
  logic [17:0] lo_q, up_q, hi_q, pl_q;
  logic fl_q, pdx_q;
  wire ans = ctl_ack || ctl_nak;
  wire tone = ctl_reg == 8'h05 || ctl_reg == 8'h06;
  wire gain = ctl_reg == 8'h07 || ctl_reg == 8'h08;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      lo_q <= 18'h0;
      up_q <= 18'h0;
      hi_q <= 18'h0;
      pl_q <= 18'h0;
    end else begin
      lo_q <= (!rst_b) ? lo_q + 18'h1 : 18'h0;
      up_q <= (rst_b) ? up_q + 18'h1 : 18'h0;
      hi_q <= (low_power_request_pin) ? hi_q + 18'h1 : 18'h0;
      pl_q <= (!low_power_request_pin) ? pl_q + 18'h1 : 18'h0;
    end
  end

  // Mirror of the fast-load bit as seen on the wire
  always_ff @(posedge i_clk) begin
    if (!rst_b) begin
      fl_q <= 1'b1;
      pdx_q <= i_rst_b && (pdx_q || $fell(low_power_request_pin));
    end else begin
      pdx_q <= 1'b0;
      if (ctl_ack && ctl_we && ctl_reg == 8'h01) begin
        fl_q <= ctl_wdata[7];
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_tone_fl;
    ctl_req && ctl_we && tone && fl_q;
  endsequence
  sequence s_gain_wr;
    ctl_req && ctl_we && gain;
  endsequence

  a_silent_in_init: assert property (ans |-> up_q > INIT_CYCLES)
    else $error("Answer before init finished");
  a_silent_in_rst: assert property (!rst_b [*4] |-> !ans)
    else $error("Answer while reset pin low");
  a_ack_one_cycle: assert property (ctl_ack |=> !ctl_ack)
    else $error("Ack longer than one cycle");
  a_answer_has_req: assert property (ans |-> $past(ctl_req))
    else $error("Answer without request");
  a_ack_nak_excl: assert property (!(ctl_ack && ctl_nak))
    else $error("Ack and nak together");
  a_tone_refused: assert property (s_tone_fl ##0 ans |-> ctl_nak)
    else $error("Tone write taken in fast load");
  a_gain_taken: assert property (s_gain_wr ##0 ans |-> ctl_ack)
    else $error("Gain write refused");
  a_pd_gap: assert property ($fell(rst_b) && low_power_request_pin |-> hi_q >= GAP_CYC)
    else $error("Reset pin fell too soon after power-down");
  a_up_gap: assert property ($rose(rst_b) && pdx_q |-> pl_q >= GAP_CYC)
    else $error("Reset pin rose too soon after power-up");
  a_rst_low_min: assert property ($rose(rst_b) |-> lo_q >= RST_HOLD)
    else $error("Reset pin pulse too short");
endmodule // rfps_link_assertions
`default_nettype wire

// *** verification/rfps_tb.sv ***
// Purpose: Self-checking bench joining host and device ends
// Assumes: 40 MHz clock, short init and transfer timeout
// Notes: Software reaches the host through its Avalon slave
`timescale 1ns/1ps
`default_nettype none
module rfps_tb;
  localparam int INIT = 100;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [1:0] av_addr = 2'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata, rd;
  logic av_wait, rdy, fl, lp, acc, run;
  logic [23:0] vol, ga, gb;
  logic [7:0] bass, treb;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int waited = 0;
  rfps_link_if lnk ();

  always #12.5 i_clk = ~i_clk;

  rfps_host #(.XFER_TMO(300)) rfps_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait), .lnk(lnk.host));
  rfps_dev #(.INIT_CYCLES(INIT)) rfps_dev_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .lnk(lnk.dev), .o_ready(rdy), .o_fast_load(fl), .o_low_power(lp),
    .o_audio_accept(acc), .o_audio_run(run), .o_volume(vol), .o_gain_a(ga),
    .o_gain_b(gb), .o_bass(bass), .o_treble(treb));
  rfps_link_assertions #(.INIT_CYCLES(INIT)) rfps_link_assertions_inst (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .rst_b(lnk.rst_b), .low_power_request_pin(lnk.low_power_request_pin),
    .ctl_req(lnk.ctl_req), .ctl_we(lnk.ctl_we), .ctl_reg(lnk.ctl_reg),
    .ctl_wdata(lnk.ctl_wdata), .ctl_ack(lnk.ctl_ack), .ctl_nak(lnk.ctl_nak));

  task automatic finish_test();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= w;
    av_rd <= !w;
    do begin
      @(posedge i_clk);
    end while (av_wait !== 1'b0);
    rd = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  // Write then poll status until idle; rd ends holding status
  task automatic cmd(input logic [1:0] a, input logic [7:0] r, input logic [23:0] d);
    bus(1'b1, a, {r, d});
    do begin
      bus(1'b0, 2'h2, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask

  task automatic rreg(input logic [7:0] r);
    cmd(2'h3, r, 24'h0);
    bus(1'b0, 2'h3, 32'h0);
  endtask

  task automatic wait_dev(input logic want_lp);
    waited = 0;
    while ((want_lp ? lp : rdy) !== 1'b1 && waited < 1000) begin
      @(posedge i_clk);
      waited++;
    end
    chk(32'(waited < 1000), 32'h1);
  endtask

  task automatic t_init();
    wait_dev(1'b0);
    chk(32'(waited >= INIT), 32'h1);
    chk(32'({fl, acc, run, lp}), 32'h8);
    chk(32'(ga), 32'h100000);
    chk(32'(vol), 32'h0);
    chk(32'(gb), 32'h0);
    chk(32'({bass, treb}), 32'h0);
    for (int i = 0; i < 60; i += 7) begin
      rreg(8'h40 + 8'(i));
      chk(32'(rd[23:0]), (i % 5 == 0) ? 32'h100000 : 32'h0);
    end
  endtask

  task automatic t_fast();
    for (int r = 5; r < 7; r++) begin
      cmd(2'h1, 8'(r), 24'h00000C);
      chk(32'(rd[3:1]), 32'h2);
    end
    chk(32'({bass, treb}), 32'h0);
    cmd(2'h1, 8'h7C, 24'h1);
    chk(32'(rd[3:1]), 32'h2);
    cmd(2'h1, 8'h08, 24'h0ABCDE);
    chk(32'(rd[3:1]), 32'h1);
    chk(32'(gb), 32'h0ABCDE);
    cmd(2'h1, 8'h42, 24'h012345);
    chk(32'(rd[3:1]), 32'h1);
    rreg(8'h42);
    chk(32'(rd[23:0]), 32'h012345);
    chk(32'(vol), 32'h0);
    cmd(2'h1, 8'h01, 24'h0);
    chk(32'({fl, acc, run}), 32'h3);
    cmd(2'h1, 8'h06, 24'h00000C);
    chk(32'({rd[3:1], bass}), 32'h10C);
    cmd(2'h1, 8'h07, 24'h080000);
    chk(32'(ga), 32'h080000);
  endtask

  task automatic t_pd();
    int c0;
    bus(1'b1, 2'h0, 32'h00000020);
    wait_dev(1'b1);
    chk(32'({lp, rdy, acc, run}), 32'h8);
    bus(1'b0, 2'h2, 32'h0);
    chk(32'(rd[5:4]), 32'h3);
    repeat (50) @(posedge i_clk);
    chk(32'({lp, rdy}), 32'h2);
    cmd(2'h0, 8'h0, 24'h00004A);
    c0 = cyc;
    cmd(2'h1, 8'h08, 24'h000055);
    chk(32'(cyc - c0 > 80), 32'h1);
    chk(32'({rd[3:1], lp}), 32'h2);
    chk(32'(fl), 32'h1);
    chk(32'(ga), 32'h100000);
    chk(32'(gb), 32'h000055);
    rreg(8'h42);
    chk(32'(rd[23:0]), 32'h0);
  endtask

  task automatic t_rst();
    cmd(2'h1, 8'h01, 24'h0);
    cmd(2'h0, 8'h0, 24'h00001A);
    wait_dev(1'b0);
    chk(32'({fl, acc}), 32'h2);
    chk(32'(vol), 32'h0);
    chk(32'(gb), 32'h0);
    cmd(2'h0, 8'h0, 24'h000006);
    cmd(2'h1, 8'h04, 24'h000777);
    chk(32'({rd[3:1], vol}), 32'h4000000);
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_init();
    t_fast();
    t_pd();
    t_rst();
    finish_test();
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
endmodule // rfps_tb
`default_nettype wire
